// *** hw/hdrc_pkg.sv ***
// shared constants, register map and compander maths for the hdr pixel path
package hdrc_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] EXPOSURE_RATIO_CONTROL_IDX = 16'h3082;
  localparam logic [15:0] EXPOSURE_RATIO_CONTROL_ALT_IDX = 16'h3084;
  localparam logic [15:0] MOTION_CORRECTION_CONTROL_IDX = 16'h318C;
  localparam logic [15:0] COMPANDER_ENABLE_IDX = 16'h31D0;
  localparam logic [15:0] RESET_CONTROL_IDX = 16'h301A;
  localparam logic [15:0] LONG_ROWS_IDX = 16'h3200;
  localparam logic [15:0] FRAME_ROWS_IDX = 16'h3201;
  localparam logic [15:0] MODE_CONTROL_IDX = 16'h3202;
  localparam logic [15:0] LONG_LIMIT_STATUS_IDX = 16'h3203;
  localparam logic [15:0] SHORT_STATUS_IDX = 16'h3204;

  // ==========================================================
  // field positions and reset values
  localparam int RATIO_SEL_LSB = 2;
  localparam int MOTION_EN_BIT = 14;
  localparam int SOFT_RESET_BIT = 0;
  localparam int WIDE_MODE_BIT = 0;
  localparam int SHORT_RATIO_LSB = 16;
  localparam logic [1:0] RATIO_SEL_RST = 2'h2;
  localparam logic [15:0] LONG_ROWS_RST = 16'h0010;
  localparam logic [15:0] FRAME_ROWS_RST = 16'h0465;

  // ==========================================================
  // exposure limits
  localparam logic [15:0] LINE_BUFFERS = 16'h0046;
  localparam logic [15:0] WIDE_FRAME_MARGIN = 16'h0047;
  localparam logic [15:0] LINEAR_FRAME_MARGIN = 16'h0001;
  localparam logic [11:0] SATURATED = 12'hFFF;

  // ==========================================================
  // compander knees
  localparam logic [15:0] KNEE_IN_1 = 16'h0400;
  localparam logic [15:0] KNEE_IN_2 = 16'h1000;
  localparam logic [15:0] KNEE_IN_3 = 16'h8000;
  localparam logic [11:0] KNEE_OUT_1 = 12'h400;
  localparam logic [11:0] KNEE_OUT_2 = 12'hA00;
  localparam logic [11:0] KNEE_OUT_3 = 12'hD80;
  localparam logic [11:0] SEG2_BIAS = 12'h200;
  localparam logic [11:0] SEG3_BIAS = 12'h980;

  // 16-bit linear value to 12-bit code
  function automatic logic [11:0] hdrc_compand(input logic [15:0] lin);
    logic [11:0] code;
    code = 12'h000;
    if (lin < KNEE_IN_1)
    begin
      code = lin[11:0];
    end
    else if (lin < KNEE_IN_2)
    begin
      code = {1'b0, lin[11:1]} + SEG2_BIAS;
    end
    else if (lin < KNEE_IN_3)
    begin
      code = {2'b00, lin[14:5]} + SEG3_BIAS;
    end
    else
    begin
      code = {3'b000, lin[14:6]} + KNEE_OUT_3;
    end
    return code;
  endfunction : hdrc_compand

  // 12-bit code back to 16-bit linear value
  function automatic logic [15:0] hdrc_decompand(input logic [11:0] code);
    logic [15:0] lin;
    lin = 16'h0000;
    if (code < KNEE_OUT_1)
    begin
      lin = {4'h0, code};
    end
    else if (code < KNEE_OUT_2)
    begin
      lin = {3'b000, code - KNEE_OUT_1, 1'b0} + KNEE_IN_1;
    end
    else if (code < KNEE_OUT_3)
    begin
      lin = {code[10:0] - 11'h200, 5'h00} + KNEE_IN_2;
    end
    else
    begin
      lin = {code[9:0] - 10'h180, 6'h00} + KNEE_IN_3;
    end
    return lin;
  endfunction : hdrc_decompand

endpackage : hdrc_pkg

// *** hw/hdrc_link_if.sv ***
// pixel link between the sensor path and the downstream receiver
`timescale 1ns/1ps
`default_nettype none
interface hdrc_link_if;
  logic [15:0] pix_code;
  logic pix_valid;
  logic pix_ready;
  logic pix_companded;
  logic [1:0] pix_ratio_sel;
  logic frame_restart;

  modport sensor (
    output pix_code,
    output pix_valid,
    input pix_ready,
    output pix_companded,
    output pix_ratio_sel,
    output frame_restart
  );

  modport receiver (
    input pix_code,
    input pix_valid,
    output pix_ready,
    input pix_companded,
    input pix_ratio_sel,
    input frame_restart
  );
endinterface : hdrc_link_if
`default_nettype wire

// *** hw/hdrc_buf2.sv ***
// two-entry valid/ready buffer with synchronous flush
`timescale 1ns/1ps
`default_nettype none
module hdrc_buf2 #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // flush wins so an aborted frame leaves nothing behind
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
    end
    else if (flush)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : hdrc_buf2
`default_nettype wire

// *** hw/hdrc_sensor.sv ***
// sensor end: exposure merge, pre-shift, compander and exposure limits
//
// Summary of operation
// - compand 16-bit linear pixels to 12 bits
// - compand only when enable register set
// - four segment piecewise linear compression formulas
// - output knees at 1024, 2560, 3456
// - receiver decompands each segment back
// - pre-shift narrow ratios to fill 16 bits
// - two-bit field picks 4x to 32x
// - receiver unshifts by ratio after decompanding
// - 70 line buffers cap long rows in wide mode
// - over cap: short rows 70, ratio computed
// - receiver keeps using programmed ratio
// - long rows max frame-1 or frame-71
// - long rows clamped up to minimum exposure rows
// - motion bit 14 enables correction
// - reset by pin or reset register
// - merge two exposures into 16-bit value
// - soft reset bit aborts frame, self clears
`timescale 1ns/1ps
`default_nettype none
module hdrc_sensor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // exposure pairs from the pixel array
  input wire logic exp_valid,
  output logic exp_ready,
  input wire logic [11:0] long_exposure,
  input wire logic [11:0] short_exposure,
  // status pins
  output logic motion_correct_en,
  // link to receiver
  hdrc_link_if.sensor link
);
  // ==========================================================
  // registers
  logic [15:0] ratio_ctrl_reg;
  logic [15:0] ratio_ctrl_alt_reg;
  logic [15:0] motion_ctrl_reg;
  logic [15:0] comp_en_reg;
  logic [15:0] long_rows_reg;
  logic [15:0] frame_rows_reg;
  logic wide_dynamic_mode_reg;
  logic soft_rst_reg;
  logic [15:0] long_limit_reg;
  logic [15:0] short_rows_reg;
  logic [15:0] eff_ratio_reg;
  logic s1_valid_reg;
  logic [15:0] s1_lin_reg;
  logic [1:0] ratio_sel;
  logic [15:0] idx;
  logic setup;
  logic wr_en;
  logic hit;
  logic [31:0] rd_next;
  logic buf_ready;
  logic buf_valid;
  logic [15:0] buf_data;

  assign ratio_sel = ratio_ctrl_reg[hdrc_pkg::RATIO_SEL_LSB +: 2];
  assign idx = paddr[17:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;

  // ==========================================================
  // apb slave: zero wait, unmapped reads zero with pslverr
  always_comb
  begin
    hit = 1'b1;
    rd_next = 32'h0000_0000;
    case (idx)
      hdrc_pkg::EXPOSURE_RATIO_CONTROL_IDX: rd_next = {16'h0000, ratio_ctrl_reg};
      hdrc_pkg::EXPOSURE_RATIO_CONTROL_ALT_IDX:
        rd_next = {16'h0000, ratio_ctrl_alt_reg};
      hdrc_pkg::MOTION_CORRECTION_CONTROL_IDX:
        rd_next = {16'h0000, motion_ctrl_reg};
      hdrc_pkg::COMPANDER_ENABLE_IDX: rd_next = {16'h0000, comp_en_reg};
      hdrc_pkg::RESET_CONTROL_IDX: rd_next = 32'h0000_0000;
      hdrc_pkg::LONG_ROWS_IDX: rd_next = {16'h0000, long_rows_reg};
      hdrc_pkg::FRAME_ROWS_IDX: rd_next = {16'h0000, frame_rows_reg};
      hdrc_pkg::MODE_CONTROL_IDX: rd_next = {31'h0, wide_dynamic_mode_reg};
      hdrc_pkg::LONG_LIMIT_STATUS_IDX: rd_next = {16'h0000, long_limit_reg};
      hdrc_pkg::SHORT_STATUS_IDX: rd_next = {eff_ratio_reg, short_rows_reg};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rd_next : 32'h0000_0000;
      pslverr <= setup && !hit;
    end
  end

  // ratio field written here; codes 0..3 are 4x..32x
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ratio_ctrl_reg <= {12'h000, hdrc_pkg::RATIO_SEL_RST, 2'b00};
      ratio_ctrl_alt_reg <= {12'h000, hdrc_pkg::RATIO_SEL_RST, 2'b00};
      motion_ctrl_reg <= 16'h0000;
      comp_en_reg <= 16'h0000;
      long_rows_reg <= hdrc_pkg::LONG_ROWS_RST;
      frame_rows_reg <= hdrc_pkg::FRAME_ROWS_RST;
      wide_dynamic_mode_reg <= 1'b1;
    end
    else if (wr_en)
    begin
      case (idx)
        hdrc_pkg::EXPOSURE_RATIO_CONTROL_IDX: ratio_ctrl_reg <= pwdata[15:0];
        hdrc_pkg::EXPOSURE_RATIO_CONTROL_ALT_IDX:
          ratio_ctrl_alt_reg <= pwdata[15:0];
        hdrc_pkg::MOTION_CORRECTION_CONTROL_IDX:
          motion_ctrl_reg <= pwdata[15:0];
        hdrc_pkg::COMPANDER_ENABLE_IDX: comp_en_reg <= pwdata[15:0];
        hdrc_pkg::LONG_ROWS_IDX: long_rows_reg <= pwdata[15:0];
        hdrc_pkg::FRAME_ROWS_IDX: frame_rows_reg <= pwdata[15:0];
        hdrc_pkg::MODE_CONTROL_IDX:
          wide_dynamic_mode_reg <= pwdata[hdrc_pkg::WIDE_MODE_BIT];
        default: ;
      endcase
    end
  end

  // one-cycle soft reset pulse, reads back zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_rst_reg <= 1'b0;
    end
    else
    begin
      soft_rst_reg <= wr_en && (idx == hdrc_pkg::RESET_CONTROL_IDX)
        && pwdata[hdrc_pkg::SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      motion_correct_en <= 1'b0;
    end
    else
    begin
      motion_correct_en <= motion_ctrl_reg[hdrc_pkg::MOTION_EN_BIT];
    end
  end

  // ==========================================================
  // exposure limits
  logic [15:0] ratio_x;
  logic [15:0] buf_cap;
  logic [15:0] frame_cap;
  logic [15:0] max_rows;
  logic [15:0] min_rows;
  logic [15:0] long_eff;

  always_comb
  begin
    ratio_x = 16'h0004 << ratio_sel;
    // buffer cap is 70 times the ratio
    // shift amount widened: ratio_sel + 2 overflows two bits at 16x
    buf_cap = hdrc_pkg::LINE_BUFFERS << ({1'b0, ratio_sel} + 3'd2);
    if (wide_dynamic_mode_reg)
    begin
      frame_cap = frame_rows_reg - hdrc_pkg::WIDE_FRAME_MARGIN;
      max_rows = (buf_cap < frame_cap) ? buf_cap : frame_cap;
      min_rows = ratio_x >> 1;
    end
    else
    begin
      frame_cap = frame_rows_reg - hdrc_pkg::LINEAR_FRAME_MARGIN;
      max_rows = frame_cap;
      min_rows = 16'h0001;
    end
    // clamp upward when software programs too few rows
    long_eff = (long_rows_reg > max_rows) ? max_rows : long_rows_reg;
    if (long_eff < min_rows)
    begin
      long_eff = min_rows;
    end
  end

  // short rows held at 70 once the cap is passed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      long_limit_reg <= 16'h0000;
      short_rows_reg <= 16'h0000;
      eff_ratio_reg <= 16'h0000;
    end
    else
    begin
      long_limit_reg <= long_eff;
      if (long_rows_reg > buf_cap)
      begin
        short_rows_reg <= hdrc_pkg::LINE_BUFFERS;
        eff_ratio_reg <= long_rows_reg / hdrc_pkg::LINE_BUFFERS;
      end
      else
      begin
        short_rows_reg <= long_eff >> ({1'b0, ratio_sel} + 3'd2);
        eff_ratio_reg <= ratio_x;
      end
    end
  end

  // ==========================================================
  // pixel path
  logic [15:0] merged;
  logic s1_adv;

  // long unless saturated in wide mode, else short scaled by ratio
  // aligned so every ratio fills 16 bits
  always_comb
  begin
    merged = {short_exposure, 4'h0};
    if (long_exposure != hdrc_pkg::SATURATED || !wide_dynamic_mode_reg)
    begin
      case (ratio_sel)
        2'd0: merged = {2'b00, long_exposure, 2'b00};
        2'd1: merged = {3'b000, long_exposure, 1'b0};
        2'd2: merged = {4'h0, long_exposure};
        2'd3: merged = {5'b00000, long_exposure[11:1]};
        default: merged = 16'h0000;
      endcase
    end
  end

  assign s1_adv = !s1_valid_reg || buf_ready;
  assign exp_ready = s1_adv && !soft_rst_reg;

  // pin reset or soft reset clears the pipe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_valid_reg <= 1'b0;
      s1_lin_reg <= 16'h0000;
    end
    else if (soft_rst_reg)
    begin
      s1_valid_reg <= 1'b0;
    end
    else if (s1_adv)
    begin
      s1_valid_reg <= exp_valid;
      s1_lin_reg <= merged;
    end
  end

  hdrc_buf2 #(.W(16)) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .flush(soft_rst_reg),
    .in_valid(s1_valid_reg),
    .in_ready(buf_ready),
    .in_data(comp_en_reg[0] ? {4'h0, hdrc_pkg::hdrc_compand(s1_lin_reg)}
                            : s1_lin_reg),
    .out_valid(buf_valid),
    .out_ready(link.pix_ready),
    .out_data(buf_data)
  );

  assign link.pix_valid = buf_valid;
  assign link.pix_code = buf_data;
  // programmed ratio is sent so the receiver need not track the limit
  assign link.pix_companded = comp_en_reg[0];
  assign link.pix_ratio_sel = ratio_sel;
  assign link.frame_restart = soft_rst_reg;
endmodule : hdrc_sensor
`default_nettype wire

// *** hw/hdrc_receiver.sv ***
// receiver end: decompand and unshift companded pixels
`timescale 1ns/1ps
`default_nettype none
module hdrc_receiver (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link from sensor
  hdrc_link_if.receiver link,
  // linear pixels out
  output logic lin_valid,
  input wire logic lin_ready,
  output logic [16:0] lin_data,
  output logic restart_seen
);
  logic buf_valid;
  logic [15:0] buf_data;
  logic adv;
  logic [15:0] relin;
  logic [16:0] unshifted;

  // mode and ratio are live register copies: reconfigure only when drained
  hdrc_buf2 #(.W(16)) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .flush(link.frame_restart),
    .in_valid(link.pix_valid),
    .in_ready(link.pix_ready),
    .in_data(link.pix_code),
    .out_valid(buf_valid),
    .out_ready(adv),
    .out_data(buf_data)
  );

  assign adv = !lin_valid || lin_ready;

  // ==========================================================
  // relinearise
  always_comb
  begin
    relin = link.pix_companded ? hdrc_pkg::hdrc_decompand(buf_data[11:0])
                               : buf_data;
    case (link.pix_ratio_sel)
      2'd0: unshifted = {3'b000, relin[15:2]};
      2'd1: unshifted = {2'b00, relin[15:1]};
      2'd2: unshifted = {1'b0, relin};
      2'd3: unshifted = {relin, 1'b0};
      default: unshifted = 17'h0_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lin_valid <= 1'b0;
      lin_data <= 17'h0_0000;
      restart_seen <= 1'b0;
    end
    else
    begin
      restart_seen <= link.frame_restart;
      if (link.frame_restart)
      begin
        lin_valid <= 1'b0;
      end
      else if (adv)
      begin
        lin_valid <= buf_valid;
        lin_data <= unshifted;
      end
    end
  end
endmodule : hdrc_receiver
`default_nettype wire

// *** tb/hdrc_link_chk.sv ***
// assertions on the pixel link between the sensor and receiver ends
`timescale 1ns/1ps
`default_nettype none
module hdrc_link_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire logic [15:0] pix_code,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic pix_companded,
  input wire logic [1:0] pix_ratio_sel,
  input wire logic frame_restart
);
  // ==========
  // clocking
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========
  // link rules
  hold_code_a: assert property (
    pix_valid && !pix_ready && !frame_restart
    |=> pix_valid && $stable(pix_code))
    else $error("pixel word moved while stalled");
  hold_attr_a: assert property (
    pix_valid && !pix_ready |=> $stable({pix_companded, pix_ratio_sel}))
    else $error("pixel attributes moved while stalled");
  code_range_a: assert property (
    pix_valid && pix_companded |-> pix_code <= 16'h0F7F)
    else $error("companded code above top knee range");
  seg1_keep_a: assert property (
    pix_valid && pix_companded && pix_ratio_sel == 2'h0 &&
    pix_code < 16'h0400 |-> pix_code[1:0] == 2'h0)
    else $error("low segment code not passed unchanged");
  shift_4x_a: assert property (
    pix_valid && !pix_companded && pix_ratio_sel == 2'h0
    |-> pix_code[1:0] == 2'h0)
    else $error("4x data not shifted up by two");
  shift_8x_a: assert property (
    pix_valid && !pix_companded && pix_ratio_sel == 2'h1 |-> !pix_code[0])
    else $error("8x data not shifted up by one");
  restart_pulse_a: assert property (frame_restart |=> !frame_restart)
    else $error("restart longer than one cycle");
  restart_flush_a: assert property (frame_restart |=> !pix_valid)
    else $error("pixel survived a restart");
  reset_idle_a: assert property (
    $rose(presetn) |-> !pix_valid && !frame_restart)
    else $error("link busy right after reset");
endmodule : hdrc_link_chk
`default_nettype wire

// *** tb/hdr_companding_exposure_limits_tb.sv ***
// bench for both ends of the hdr pixel path joined by the link
`timescale 1ns/1ps
`default_nettype none
module hdr_companding_exposure_limits_tb;
  // ==========
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic exp_valid = 1'b0;
  logic lin_ready = 1'b1;
  logic [11:0] long_exposure = 12'h000;
  logic [11:0] short_exposure = 12'h000;
  logic [31:0] prdata, rd;
  logic [16:0] lin_data;
  logic pready, pslverr, exp_ready, motion_correct_en, lin_valid;
  logic restart_seen, er;
  logic stall = 1'b0;
  logic wide = 1'b1;
  logic comp = 1'b0;
  logic [1:0] ratio = 2'h2;
  logic [15:0] pq[$];
  logic [16:0] lq[$];
  int err_total = 0;
  int checks = 0;
  int restarts = 0;
  int refusals = 0;
  logic [15:0] ri [8] = '{16'h3082, 16'h3084, 16'h318C, 16'h31D0,
    16'h301A, 16'h3200, 16'h3201, 16'h3202};
  logic [15:0] rv [8] = '{16'h0008, 16'h0008, 16'h0000, 16'h0000,
    16'h0000, 16'h0010, 16'h0465, 16'h0001};
  logic [11:0] tl [8] = '{12'h000, 12'h3FF, 12'h400, 12'hFFE, 12'hFFF,
    12'hFFF, 12'hFFF, 12'hFFF};
  logic [11:0] ts [8] = '{12'h5A5, 12'h001, 12'h002, 12'h003, 12'h0FF,
    12'h100, 12'h800, 12'hFFF};
  logic [15:0] lr [3] = '{16'h0000, 16'h07D0, 16'hFFFF};

  always #2.5 pclk = ~pclk;

  hdrc_link_if link ();
  hdrc_sensor i_hdrc_sensor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exp_valid(exp_valid), .exp_ready(exp_ready),
    .long_exposure(long_exposure), .short_exposure(short_exposure),
    .motion_correct_en(motion_correct_en), .link(link.sensor));
  hdrc_receiver i_hdrc_receiver (.pclk(pclk), .presetn(presetn),
    .link(link.receiver), .lin_valid(lin_valid), .lin_ready(lin_ready),
    .lin_data(lin_data), .restart_seen(restart_seen));
  hdrc_link_chk i_hdrc_link_chk (.pclk(pclk), .presetn(presetn),
    .pix_code(link.pix_code), .pix_valid(link.pix_valid),
    .pix_ready(link.pix_ready), .pix_companded(link.pix_companded),
    .pix_ratio_sel(link.pix_ratio_sel), .frame_restart(link.frame_restart));

  // ==========
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("BAD at %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic give_up();
    err_total++;
    $display("BAD at %0t wait bound used up", $time);
    final_report();
  endtask : give_up

  task automatic wait_sig(input bit on_apb);
    int n;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((on_apb ? pready : exp_ready) !== 1'b1 && n < 300);
    if (n >= 300)
      give_up();
  endtask : wait_sig

  // one idle cycle after each transfer keeps psel from double driving
  task automatic apb(input logic wr, input logic [15:0] idx,
    input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    wait_sig(1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [15:0] idx, input logic [15:0] want);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, {16'h0000, want});
  endtask : rchk

  function automatic logic [11:0] cmp(input int v);
    if (v < 1024)
      return 12'(v);
    if (v < 4096)
      return 12'((v - 1024) / 2 + 1024);
    if (v < 32768)
      return 12'((v - 4096) / 32 + 2560);
    return 12'((v - 32768) / 64 + 3456);
  endfunction : cmp

  function automatic int dec(input int c);
    if (c < 1024)
      return c;
    if (c < 2560)
      return (c - 1024) * 2 + 1024;
    if (c < 3456)
      return (c - 2560) * 32 + 4096;
    return (c - 3456) * 64 + 32768;
  endfunction : dec

  // merge then pre-shift to 16 bits; valid stays up for the next
  task automatic pix(input logic [11:0] lg, input logic [11:0] sh);
    int v;
    int d;
    v = (wide && lg == 12'hFFF) ? sh * 16 : lg * 16 / (4 << ratio);
    d = comp ? dec(cmp(v)) : v;
    pq.push_back(comp ? 16'(cmp(v)) : 16'(v));
    lq.push_back(17'(d * (4 << ratio) / 16));
    exp_valid <= 1'b1;
    long_exposure <= lg;
    short_exposure <= sh;
    wait_sig(1'b0);
  endtask : pix

  task automatic drain();
    int n;
    n = 0;
    exp_valid <= 1'b0;
    while ((pq.size() != 0 || lq.size() != 0) && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000)
      give_up();
  endtask : drain

  // ==========
  // receiver stalls and result watcher
  always @(posedge pclk)
    lin_ready <= stall ? 1'b0 : ($urandom % 3 != 0);

  always @(posedge pclk)
  begin
    if ((exp_valid & ~exp_ready) === 1'b1)
      refusals++;
    if (restart_seen === 1'b1)
      restarts++;
    if ((link.pix_valid & link.pix_ready) === 1'b1)
    begin
      chk({link.pix_companded, link.pix_ratio_sel}, {comp, ratio});
      chk(link.pix_code, pq.size() ? pq.pop_front() : 'x);
    end
    if ((lin_valid & lin_ready) === 1'b1)
      chk(lin_data, lq.size() ? lq.pop_front() : 'x);
  end

  initial
  begin
    int mx;
    int lim;
    int fr;
    void'($urandom(83296));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ri[i])
      rchk(ri[i], rv[i]);
    apb(1'b0, 16'h0123, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(er, 1'b1);
    $display("test registers done");
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 2; c++)
      begin
        ratio = 2'(r);
        comp = 1'(c);
        wide = (r != 1);
        apb(1'b1, 16'h3082, 32'(r * 4));
        apb(1'b1, 16'h31D0, 32'(c));
        apb(1'b1, 16'h3202, 32'(wide));
        foreach (tl[i])
          pix(tl[i], ts[i]);
        repeat (4)
          pix(12'($urandom), 12'($urandom));
        drain();
      end
    $display("test pixels done");
    refusals = 0;
    stall <= 1'b1;
    fork
      begin
        repeat (60) @(posedge pclk);
        stall <= 1'b0;
      end
    join_none
    repeat (12)
      pix(12'($urandom), 12'h000);
    drain();
    chk(refusals > 0, 1'b1);
    $display("test buffer done");
    ratio = 2'h2;
    apb(1'b1, 16'h3082, 32'h0000_0008);
    for (int f = 0; f < 2; f++)
    begin
      fr = f ? 1024 : 4096;
      apb(1'b1, 16'h3201, 32'(fr));
      for (int w = 0; w < 2; w++)
        foreach (lr[i])
        begin
          apb(1'b1, 16'h3202, 32'(w));
          apb(1'b1, 16'h3200, 32'(lr[i]));
          mx = w ? ((70 * 16 < fr - 71) ? 70 * 16 : fr - 71) : fr - 1;
          lim = lr[i] < (w ? 8 : 1) ? (w ? 8 : 1) : lr[i] > mx ? mx : lr[i];
          rchk(16'h3203, 16'(lim));
          if (w && lr[i] > 70 * 16)
          begin
            apb(1'b1, 16'h3203, 32'h0000_0000);
            apb(1'b0, 16'h3204, 32'h0000_0000);
            chk(rd, {16'(lr[i] / 70), 16'h0046});
          end
        end
    end
    $display("test limits done");
    apb(1'b1, 16'h318C, 32'h0000_4000);
    repeat (2) @(posedge pclk);
    chk(motion_correct_en, 1'b1);
    apb(1'b1, 16'h318C, 32'h0000_BFFF);
    repeat (2) @(posedge pclk);
    chk(motion_correct_en, 1'b0);
    $display("test motion done");
    ratio = 2'h3;
    apb(1'b1, 16'h3082, 32'h0000_000C);
    // fill both ends while stalled so the abort has words to drop
    stall <= 1'b1;
    repeat (6)
      pix(12'($urandom), 12'($urandom));
    exp_valid <= 1'b0;
    restarts = 0;
    apb(1'b1, 16'h301A, 32'h0000_0001);
    pq.delete();
    lq.delete();
    stall <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(restarts, 1);
    rchk(16'h301A, 16'h0000);
    rchk(16'h3082, 16'h000C);
    $display("test soft reset done");
    apb(1'b1, 16'h31D0, 32'h0000_0001);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(16'h31D0, 16'h0000);
    rchk(16'h3082, 16'h0008);
    $display("test pin reset done");
    final_report();
  end
endmodule : hdr_companding_exposure_limits_tb
`default_nettype wire
